/* src/ssg_pkg.sv */
// Purpose: Shared constants, opcodes and carriers for the sensor status groups.
// Assumes: One core clock; all engine strobes are synchronous to it.
// Notes:   Bit positions and opcodes are named once here and used by name.
package ssg_pkg;

    // Group geometry
    localparam int unsigned GRP_W      = 16;
    localparam int unsigned NUM_GRP    = 3;
    localparam int unsigned STB_W      = 8;

    // Group indices on the command port
    localparam logic [1:0] GRP_QUAL    = 2'h0;
    localparam logic [1:0] GRP_OPER    = 2'h1;
    localparam logic [1:0] GRP_FAULT   = 2'h2;

    // Measurement-quality group bit positions
    localparam int unsigned QB_POWER   = 3;
    localparam int unsigned QB_CAL     = 8;
    localparam int unsigned QB_SELFTST = 9;

    // Operation-progress group bit positions
    localparam int unsigned OB_CALIB   = 0;
    localparam int unsigned OB_BIST    = 1;
    localparam int unsigned OB_MEAS    = 4;
    localparam int unsigned OB_WTRIG   = 5;
    localparam int unsigned OB_NVREAD  = 10;
    localparam int unsigned OB_LOWER   = 11;
    localparam int unsigned OB_UPPER   = 12;

    // Device-fault group bit position
    localparam int unsigned FB_SENSOR  = 3;

    // Status byte positions of the group summaries
    localparam int unsigned SB_FAULT   = 1;
    localparam int unsigned SB_QUAL    = 3;
    localparam int unsigned SB_OPER    = 7;

    // Masks of implemented bits; bit 15 never appears in any of them
    localparam logic [15:0] QUAL_MASK  = 16'h0308;
    localparam logic [15:0] OPER_MASK  = 16'h1C33;
    localparam logic [15:0] FAULT_MASK = 16'h0008;

    // Reset values
    localparam logic [15:0] GRP_RST    = 16'h0000;
    localparam logic [7:0]  STB_RST    = 8'h00;

    // Reply to the operation-complete query: ASCII one
    localparam logic [15:0] OPC_REPLY  = 16'h0031;

    // Host command opcodes
    typedef enum logic [3:0] {
        SSG_OP_NONE     = 4'h0,
        SSG_OP_RD_COND  = 4'h1,
        SSG_OP_RD_EVENT = 4'h2,
        SSG_OP_RD_ENA   = 4'h3,
        SSG_OP_WR_ENA   = 4'h4,
        SSG_OP_CLS      = 4'h5,
        SSG_OP_OPC      = 4'h6,
        SSG_OP_OPC_QRY  = 4'h7,
        SSG_OP_STB_QRY  = 4'h8
    } ssg_op_t;

    // Command carrier from the host parser
    typedef struct packed {
        logic        valid;
        ssg_op_t     op;
        logic [1:0]  group;
        logic [15:0] data;
    } ssg_cmd_t;

    // Reply carrier toward the output queue
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } ssg_reply_t;

    // Strobes and levels from the measurement engine
    typedef struct packed {
        logic power_err;            // Pulse: stale/corrupt, overload or log error
        logic meas_clean;           // Pulse: measurement ended with none of those
        logic zeroing_request;      // Pulse: zeroing begins (also inside cal-all)
        logic calibration_request;  // Pulse: calibration begins
        logic cal_end;              // Pulse: zeroing or calibration ends
        logic cal_err;              // Pulse: zero or cal error reported
        logic cal_ok;               // Pulse: zero/cal command succeeded cleanly
        logic post_fail;            // Pulse: power-on self-test failed
        logic post_pass;            // Pulse: power-on self-test passed
        logic linearity_selftest;   // Pulse: linearity built-in test begins
        logic zero_noise_selftest;  // Pulse: zero-set/noise built-in test begins
        logic bist_end;             // Pulse: built-in test finishes
        logic measuring;            // Level: measurement in progress
        logic enter_wait_trig;      // Pulse: entering wait-for-trigger
        logic enter_idle;           // Pulse: entering idle
        logic nv_reading;           // Level: nonvolatile memory read active
        logic meas_done;            // Pulse: measurement done, limits valid
        logic lower_fail;           // Level at meas_done: lower test enabled and failed
        logic upper_fail;           // Level at meas_done: upper test enabled and failed
        logic nv_failed;            // Level: nonvolatile memory has failed
        logic ops_pending;          // Level: commands or operations still pending
    } ssg_engine_t;

    // State of one status group
    typedef struct packed {
        logic [15:0] cond_prev;
        logic [15:0] event_bits;
        logic [15:0] enable;
    } ssg_grp_state_t;

endpackage : ssg_pkg

/* src/ssg_group.sv */
// Purpose: One 16-bit status group: event latch, enable mask and summary.
// Assumes: Condition input is already a registered level on core_clk.
// Notes:   A rising condition in the same cycle as a clear survives the clear.
`timescale 1ns/1ps
module ssg_group #(
    parameter logic [15:0] USED_MASK = 16'h0000
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic [15:0]   cond,
    input  wire logic          event_clr,
    input  wire logic          enable_wr,
    input  wire logic [15:0]   enable_data,
    output logic [15:0]        event_bits,
    output logic [15:0]        enable,
    output logic               summary
);
    import ssg_pkg::*;

    ssg_grp_state_t state;
    ssg_grp_state_t next_state;
    logic [15:0]    rise;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_state = state;
        next_state.cond_prev = cond & USED_MASK;
        rise = cond & USED_MASK & ~state.cond_prev;
        // Sticky until cleared
        // Set wins over a clear landing in the same cycle
        if (event_clr) begin
            next_state.event_bits = rise;
        end else begin
            next_state.event_bits = state.event_bits | rise;
        end
        if (enable_wr) begin
            next_state.enable = enable_data & USED_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '{cond_prev: GRP_RST, event_bits: GRP_RST, enable: GRP_RST};
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; reading the enable does not touch it
    assign event_bits = state.event_bits;
    assign enable     = state.enable;
    assign summary    = |(state.event_bits & state.enable);

endmodule // ssg_group

/* src/ssg_status_top.sv */
// Purpose: Condition tracking, three status groups, status byte summary bits
//          and operation-complete synchronisation for a measurement sensor.
// Assumes: Engine strobes and host commands are synchronous to core_clk and
//          come from logic on the same clock, so they are not resynchronised.
// Notes:   Registers are reached through the command port, one command a
//          cycle; replies come one cycle later except the OPC query, two or more cycles later.
`timescale 1ns/1ps

module ssg_status_top (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire ssg_pkg::ssg_engine_t engine,
    input  wire ssg_pkg::ssg_cmd_t    cmd,
    output ssg_pkg::ssg_reply_t       reply,
    output logic [7:0]                stb_bits,
    output logic                      opc_event,
    output logic                      cls_pulse
);
    import ssg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Module state
    typedef struct packed {
        logic [15:0] qual_cond;
        logic [15:0] oper_cond;
        logic [15:0] fault_cond;
        logic [15:0] reply_data;
        logic        reply_valid;
        logic        opc_armed;
        logic        opcq_armed;
        logic        opc_event;
        logic        cls_pulse;
    } ssg_top_state_t;

    ssg_top_state_t state;
    ssg_top_state_t next_state;

    // Per-group wiring, indexed by group code
    logic [15:0] grp_cond    [NUM_GRP];
    logic [15:0] grp_event   [NUM_GRP];
    logic [15:0] grp_enable  [NUM_GRP];
    logic        grp_summary [NUM_GRP];
    logic        grp_clr     [NUM_GRP];
    logic        grp_wr      [NUM_GRP];

    // Decoded command strobes
    logic        is_cls;
    logic        is_rd_event;
    logic        is_wr_ena;
    logic        grp_ok;
    logic [7:0]  summary_byte;

    ////////////////////////////////////////////////////////////////////////
    // Command decode; a group code outside the three groups is ignored
    always_comb begin
        is_cls      = cmd.valid && (cmd.op == SSG_OP_CLS);
        is_rd_event = cmd.valid && (cmd.op == SSG_OP_RD_EVENT);
        is_wr_ena   = cmd.valid && (cmd.op == SSG_OP_WR_ENA);
        grp_ok      = (cmd.group == GRP_QUAL) || (cmd.group == GRP_OPER)
                      || (cmd.group == GRP_FAULT);
    end

    ////////////////////////////////////////////////////////////////////////
    // Status byte summary bits; others stay zero, owned by the byte logic
    always_comb begin
        summary_byte = STB_RST;
        summary_byte[SB_FAULT] = grp_summary[GRP_FAULT];
        summary_byte[SB_QUAL]  = grp_summary[GRP_QUAL];
        summary_byte[SB_OPER]  = grp_summary[GRP_OPER];
    end

    ////////////////////////////////////////////////////////////////////////
    // Condition tracking for the measurement-quality group
    // Where a set and a clear strobe coincide, the set is taken so that a
    // fault is never hidden by a simultaneous clean report.
    function automatic logic [15:0] qual_next(input logic [15:0] cur,
                                              input ssg_engine_t e);
        logic [15:0] q;
        q = cur;
        if (e.power_err) begin
            q[QB_POWER] = 1'b1;
        end else if (e.meas_clean) begin
            q[QB_POWER] = 1'b0;
        end
        if (e.cal_err) begin
            q[QB_CAL] = 1'b1;
        end else if (e.cal_ok) begin
            q[QB_CAL] = 1'b0;
        end
        if (e.post_fail) begin
            q[QB_SELFTST] = 1'b1;
        end else if (e.post_pass) begin
            q[QB_SELFTST] = 1'b0;
        end
        return q & QUAL_MASK;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Condition tracking for the operation-progress group
    function automatic logic [15:0] oper_next(input logic [15:0] cur,
                                              input ssg_engine_t e);
        logic [15:0] o;
        o = cur;
        // Calibrating span
        // Zeroing inside a calibrate-all also raises this start strobe
        if (e.zeroing_request || e.calibration_request) begin
            o[OB_CALIB] = 1'b1;
        end else if (e.cal_end) begin
            o[OB_CALIB] = 1'b0;
        end
        if (e.linearity_selftest || e.zero_noise_selftest) begin
            o[OB_BIST] = 1'b1;
        end else if (e.bist_end) begin
            o[OB_BIST] = 1'b0;
        end
        o[OB_MEAS] = e.measuring;
        if (e.enter_wait_trig) begin
            o[OB_WTRIG] = 1'b1;
        end else if (e.enter_idle) begin
            o[OB_WTRIG] = 1'b0;
        end
        o[OB_NVREAD] = e.nv_reading;
        // Lower and upper limit results
        // Fail inputs already fold in whether each test is enabled
        if (e.meas_done) begin
            o[OB_LOWER] = e.lower_fail;
            o[OB_UPPER] = e.upper_fail;
        end
        return o & OPER_MASK;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: conditions, replies and operation-complete tracking
    always_comb begin
        next_state             = state;
        next_state.reply_valid = 1'b0;
        next_state.opc_event   = 1'b0;
        next_state.cls_pulse   = is_cls;

        next_state.qual_cond  = qual_next(state.qual_cond, engine);
        next_state.oper_cond  = oper_next(state.oper_cond, engine);
        next_state.fault_cond = GRP_RST;
        next_state.fault_cond[FB_SENSOR] = engine.nv_failed;
        next_state.fault_cond = next_state.fault_cond & FAULT_MASK;

        // Register reads answer one cycle after the command
        if (cmd.valid && grp_ok && (cmd.op == SSG_OP_RD_COND)) begin
            next_state.reply_valid = 1'b1;
            next_state.reply_data  = grp_cond[cmd.group];
        end else if (is_rd_event && grp_ok) begin
            next_state.reply_valid = 1'b1;
            next_state.reply_data  = grp_event[cmd.group];
        end else if (cmd.valid && grp_ok && (cmd.op == SSG_OP_RD_ENA)) begin
            next_state.reply_valid = 1'b1;
            next_state.reply_data  = grp_enable[cmd.group];
        end else if (cmd.valid && (cmd.op == SSG_OP_STB_QRY)) begin
            next_state.reply_valid = 1'b1;
            next_state.reply_data  = {8'h00, summary_byte};
        end

        if (cmd.valid && (cmd.op == SSG_OP_OPC)) begin
            next_state.opc_armed = 1'b1;
        end
        if (cmd.valid && (cmd.op == SSG_OP_OPC_QRY)) begin
            next_state.opcq_armed = 1'b1;
        end

        // Completion is judged on registered arm flags, so the command
        // that arms never sees its own cycle's pending level; this costs
        // one cycle but keeps ordering against the pending flag clean.
        // Set event bit 0
        if (state.opc_armed && !engine.ops_pending) begin
            next_state.opc_armed = 1'b0;
            next_state.opc_event = 1'b1;
        end
        // Queue ASCII one
        // Only when no register reply is due this cycle, so none is lost
        if (state.opcq_armed && !engine.ops_pending && !next_state.reply_valid) begin
            next_state.opcq_armed  = 1'b0;
            next_state.reply_valid = 1'b1;
            next_state.reply_data  = OPC_REPLY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '{qual_cond: GRP_RST, oper_cond: GRP_RST, fault_cond: GRP_RST,
                       reply_data: GRP_RST, reply_valid: 1'b0, opc_armed: 1'b0,
                       opcq_armed: 1'b0, opc_event: 1'b0, cls_pulse: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Condition vectors presented to the groups
    assign grp_cond[GRP_QUAL]  = state.qual_cond;
    assign grp_cond[GRP_OPER]  = state.oper_cond;
    assign grp_cond[GRP_FAULT] = state.fault_cond;

    ////////////////////////////////////////////////////////////////////////
    // The three status groups
    for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
        localparam logic [15:0] MASK = (g == GRP_QUAL) ? QUAL_MASK :
                                       (g == GRP_OPER) ? OPER_MASK : FAULT_MASK;

        assign grp_clr[g] = is_cls || (is_rd_event && (cmd.group == 2'(g)));
        assign grp_wr[g]  = is_wr_ena && (cmd.group == 2'(g));

        ssg_group #(
            .USED_MASK   (MASK)
        ) u_group (
            .core_clk    (core_clk),
            .rst_n       (rst_n),
            .cond        (grp_cond[g]),
            .event_clr   (grp_clr[g]),
            .enable_wr   (grp_wr[g]),
            .enable_data (cmd.data),
            .event_bits  (grp_event[g]),
            .enable      (grp_enable[g]),
            .summary     (grp_summary[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reply.valid = state.reply_valid;
    assign reply.data  = state.reply_data;
    assign stb_bits    = summary_byte;   // Combinational from group registers
    assign opc_event   = state.opc_event;
    assign cls_pulse   = state.cls_pulse;

endmodule // ssg_status_top

/* bench/ssg_status_assertions.sv */
// Purpose: Port-level checks of the sensor status groups.
// Assumes: One clock; one host command a cycle.
// Notes:   Bound to the top module; sees only its ports.
`timescale 1ns/1ps
module ssg_status_assertions (
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    input wire ssg_pkg::ssg_engine_t engine,
    input wire ssg_pkg::ssg_cmd_t    cmd,
    input wire ssg_pkg::ssg_reply_t  reply,
    input wire logic [7:0]           stb_bits,
    input wire logic                 opc_event,
    input wire logic                 cls_pulse
);
    import ssg_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////////////
    // Read command decode and implemented bits of the addressed group
    logic        rd_cmd;
    logic [15:0] grp_mask;
    assign rd_cmd = cmd.valid && cmd.group != 2'h3 && cmd.op inside
        {SSG_OP_RD_COND, SSG_OP_RD_EVENT, SSG_OP_RD_ENA, SSG_OP_STB_QRY};
    assign grp_mask = (cmd.group == GRP_QUAL) ? QUAL_MASK :
                      (cmd.group == GRP_OPER) ? OPER_MASK : FAULT_MASK;
    // A read due in the same cycle defers the query reply, so exclude it
    sequence s_qry_free;
        cmd.valid && cmd.op == SSG_OP_OPC_QRY ##1 !engine.ops_pending && !rd_cmd;
    endsequence
    sequence s_opc_free;
        cmd.valid && cmd.op == SSG_OP_OPC ##1 !engine.ops_pending;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////////////
    chk_opc_reply: assert property (
        s_qry_free |=> reply.valid && reply.data == OPC_REPLY)
        else $error("query reply missing");
    chk_opc_done: assert property (s_opc_free |=> opc_event)
        else $error("complete pulse missing");
    chk_read_reply: assert property (rd_cmd |=> reply.valid)
        else $error("read reply missing");
    chk_unused_zero: assert property (
        rd_cmd && cmd.op != SSG_OP_STB_QRY |=> (reply.data & ~$past(grp_mask)) == 16'h0000)
        else $error("unused bit set");
    chk_stb_spare: assert property ((stb_bits & 8'h75) == 8'h00)
        else $error("spare status byte bit set");
    chk_stb_reply: assert property (
        rd_cmd && cmd.op == SSG_OP_STB_QRY |=> reply.data == {8'h00, $past(stb_bits)})
        else $error("status byte reply wrong");
    chk_clear_pulse: assert property (
        cls_pulse == $past(cmd.valid && cmd.op == SSG_OP_CLS))
        else $error("clear pulse wrong");
    chk_level_cond: assert property (
        rd_cmd && cmd.op == SSG_OP_RD_COND && cmd.group == GRP_OPER
        && $stable(engine.measuring) && $stable(engine.nv_reading)
        |=> reply.data[OB_MEAS] == $past(engine.measuring)
        && reply.data[OB_NVREAD] == $past(engine.nv_reading))
        else $error("level condition wrong");
endmodule // ssg_status_assertions

bind ssg_status_top ssg_status_assertions chk_u (.core_clk(core_clk), .rst_n(rst_n),
    .engine(engine), .cmd(cmd), .reply(reply), .stb_bits(stb_bits),
    .opc_event(opc_event), .cls_pulse(cls_pulse));

/* bench/ssg_host_model.sv */
// Purpose: Host controller issuing status commands and collecting replies.
// Assumes: Called just after a rising edge.
// Notes:   Tasks are called from the testbench by hierarchical name.
`timescale 1ns/1ps
module ssg_host_model (
    input  wire logic                core_clk,
    input  wire ssg_pkg::ssg_reply_t reply,
    output ssg_pkg::ssg_cmd_t        cmd
);
    import ssg_pkg::*;
    initial cmd = '0;
    // host command order
    // Strobe dropped on the taking edge so a following call may raise it again
    task automatic send(input ssg_op_t op, input logic [1:0] grp, input logic [15:0] d);
        cmd = '{valid: 1'b1, op: op, group: grp, data: d};
        @(posedge core_clk);
        cmd <= '0;
        #1;
    endtask
    // Reply is registered: look just after each edge, for a bounded time
    task automatic wait_reply(input int lim, output logic got, output logic [15:0] d);
        got = 1'b0;
        d = 16'hXXXX;
        for (int i = 0; i < lim && !got; i++) begin
            if (reply.valid === 1'b1) begin
                got = 1'b1;
                d = reply.data;
            end else begin
                @(posedge core_clk);
                #1;
            end
        end
    endtask
endmodule // ssg_host_model

/* bench/tb_sensor_status_groups.sv */
// Purpose: Self-checking bench for the sensor status groups.
// Assumes: Engine strobes driven 1 ns after the rising edge.
// Notes:   Engine bits are indexed by their packed position.
`timescale 1ns/1ps
module tb_sensor_status_groups;
    import ssg_pkg::*;
    logic        core_clk;
    logic        rst_n;
    ssg_engine_t eng;
    ssg_cmd_t    cmd;
    ssg_reply_t  reply;
    logic [7:0]  stb_bits;
    logic        opc_event;
    int          n_mismatch;
    int          n_compared;
    logic        got;
    logic [15:0] d;
    logic [1:0]  g;
    logic [15:0] m;
    // Set strobe, clear strobe and bit for each pulsed condition
    int set_i [8] = '{20, 15, 13, 18, 17, 11, 10, 7};
    int clr_i [8] = '{19, 14, 12, 16, 16, 9, 9, 6};
    int bit_i [8] = '{QB_POWER, QB_CAL, QB_SELFTST, OB_CALIB, OB_CALIB, OB_BIST, OB_BIST,
                      OB_WTRIG};
    ////////////////////////////////////////////////////////////////////////////////////////
    ssg_status_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .engine(eng), .cmd(cmd),
        .reply(reply), .stb_bits(stb_bits), .opc_event(opc_event), .cls_pulse());
    ssg_host_model host_u (.core_clk(core_clk), .reply(reply), .cmd(cmd));
    always #2.5 core_clk = ~core_clk;
    task automatic report_and_stop;
        if (n_mismatch == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic pulse(input int idx);
        eng[idx] = 1'b1;
        step(1);
        eng[idx] = 1'b0;
    endtask
    task automatic rd(input ssg_op_t op, input logic [1:0] gr, input logic [15:0] exp,
                      input string what);
        host_u.send(op, gr, 16'h0000);
        host_u.wait_reply(4, got, d);
        check(what, exp, d);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the tests need under two hundred cycles, so this is far beyond
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        eng = '0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (8) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        step(1);
        // Each condition set, cleared, then its sticky event read twice
        for (int i = 0; i < 8; i++) begin
            g = (i < 3) ? GRP_QUAL : GRP_OPER;
            m = 16'h0001 << bit_i[i];
            pulse(set_i[i]);
            step(2);
            rd(SSG_OP_RD_COND, g, m, "condition set");
            pulse(clr_i[i]);
            step(2);
            rd(SSG_OP_RD_COND, g, 16'h0000, "condition clear");
            rd(SSG_OP_RD_EVENT, g, m, "event sticky");
            rd(SSG_OP_RD_EVENT, g, 16'h0000, "event cleared");
        end
        // Limit results taken at measurement done
        eng.lower_fail = 1'b1;
        pulse(4);
        step(2);
        rd(SSG_OP_RD_COND, GRP_OPER, 16'h0800, "lower limit");
        eng.lower_fail = 1'b0;
        eng.upper_fail = 1'b1;
        pulse(4);
        step(2);
        rd(SSG_OP_RD_COND, GRP_OPER, 16'h1000, "upper limit");
        eng.upper_fail = 1'b0;
        pulse(4);
        step(2);
        rd(SSG_OP_RD_COND, GRP_OPER, 16'h0000, "limits passed");
        eng.measuring = 1'b1;
        eng.nv_reading = 1'b1;
        step(2);
        rd(SSG_OP_RD_COND, GRP_OPER, 16'h0410, "level bits");
        eng.measuring = 1'b0;
        eng.nv_reading = 1'b0;
        step(2);
        rd(SSG_OP_RD_COND, GRP_OPER, 16'h0000, "levels low");
        // Enable masks and status byte summaries
        host_u.send(SSG_OP_WR_ENA, GRP_QUAL, 16'h0000);
        pulse(20);
        step(2);
        check("masked summary", 16'h0000, {8'h00, stb_bits});
        host_u.send(SSG_OP_WR_ENA, GRP_QUAL, 16'hFFFF);
        step(1);
        check("quality summary", 16'h0008, {8'h00, stb_bits});
        rd(SSG_OP_RD_ENA, GRP_QUAL, QUAL_MASK, "enable bits");
        rd(SSG_OP_RD_ENA, GRP_QUAL, QUAL_MASK, "enable reread");
        eng.nv_failed = 1'b1;
        host_u.send(SSG_OP_WR_ENA, GRP_FAULT, 16'hFFFF);
        step(2);
        rd(SSG_OP_RD_COND, GRP_FAULT, 16'h0008, "sensor error");
        rd(SSG_OP_STB_QRY, GRP_QUAL, 16'h000A, "status byte");
        rd(SSG_OP_STB_QRY, GRP_QUAL, 16'h000A, "status byte again");
        host_u.send(SSG_OP_WR_ENA, GRP_OPER, 16'hFFFF);
        pulse(18);
        step(2);
        check("operation summary", 16'h008A, {8'h00, stb_bits});
        host_u.send(SSG_OP_CLS, GRP_QUAL, 16'h0000);
        step(1);
        check("cleared summary", 16'h0000, {8'h00, stb_bits});
        rd(SSG_OP_RD_EVENT, GRP_FAULT, 16'h0000, "events after clear");
        eng.ops_pending = 1'b1;
        host_u.send(SSG_OP_OPC_QRY, GRP_QUAL, 16'h0000);
        host_u.wait_reply(6, got, d);
        check("early reply", 16'h0000, {15'h0000, got});
        eng.ops_pending = 1'b0;
        host_u.wait_reply(4, got, d);
        check("query reply", OPC_REPLY, d);
        eng.ops_pending = 1'b1;
        host_u.send(SSG_OP_OPC, GRP_QUAL, 16'h0000);
        step(4);
        check("early complete", 16'h0000, {15'h0000, opc_event});
        eng.ops_pending = 1'b0;
        step(1);
        check("complete pulse", 16'h0001, {15'h0000, opc_event});
        report_and_stop;
    end
endmodule // tb_sensor_status_groups
